// *** shared/i2c_slave_params.svh ***
// constants of the two-wire register slave port
`ifndef I2C_SLAVE_PARAMS_SVH
`define I2C_SLAVE_PARAMS_SVH

// slave address for each strap setting {high, low}
`define SLV_ADDR_00 7'h1E
`define SLV_ADDR_01 7'h1D
`define SLV_ADDR_10 7'h1C
`define SLV_ADDR_11 7'h1F

// bit counts within one byte
`define BYTE_BITS 4'h8
`define LAST_TX_BIT 4'h7

// pointer step after each data byte
`define PTR_STEP 8'h01

// synchroniser reset value, lines idle high
`define SYNC_IDLE 3'h7

`endif

// *** shared/i2c_slave_pkg.sv ***
// types of the two-wire register slave port
package i2c_slave_pkg;

    typedef enum logic [5:0] {
        S_IDLE   = 6'h01,
        S_RECV   = 6'h02,
        S_ACK    = 6'h04,
        S_SEND   = 6'h08,
        S_MACK   = 6'h10,
        S_IGNORE = 6'h20
    } slave_state_t;

    typedef enum logic [1:0] {
        PH_ADDR  = 2'h0,
        PH_INDEX = 2'h1,
        PH_DATA  = 2'h2
    } byte_phase_t;

    typedef struct packed {
        slave_state_t st;
        byte_phase_t phase;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [7:0] tx;
        logic rw;
        logic mack;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic oe;
        logic sda_o;
        logic busy;
        logic addressed;
    } slave_regs_t;

    localparam slave_regs_t SLAVE_RESET = '{st: S_IDLE, phase: PH_ADDR,
        default: '0};

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_regs_t;

    typedef struct packed {
        logic [1:0] straps;
        logic [6:0] addr;
    } map_regs_t;

endpackage

// *** shared/pin_if.sv ***
// synchronised level and edges of one input pin
`timescale 1ns/100ps
interface pin_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface

// *** rtl/pin_sync.sv ***
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
`include "i2c_slave_params.svh"
module pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    pin_if.src line
);
    import i2c_slave_pkg::*;

    sync_regs_t q, d;

    // first stage feeds only the second
    always_comb begin
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= `SYNC_IDLE;
        end else begin
            q <= d;
        end
    end

    assign line.level = q.s2;
    assign line.rise = q.s2 & ~q.s3;
    assign line.fall = ~q.s2 & q.s3;
endmodule

// *** rtl/addr_map.sv ***
// slave address chosen from the two strap levels
`timescale 1ns/100ps
`include "i2c_slave_params.svh"
module addr_map (
    input wire logic clk,
    input wire logic rst,
    pin_if.dst strap_hi,
    pin_if.dst strap_lo,
    output logic [6:0] slave_addr
);
    import i2c_slave_pkg::*;

    map_regs_t q, d;

    always_comb begin
        d.straps = {strap_hi.level, strap_lo.level};
        case (q.straps)
            2'h0: d.addr = `SLV_ADDR_00;
            2'h1: d.addr = `SLV_ADDR_01;
            2'h2: d.addr = `SLV_ADDR_10;
            default: d.addr = `SLV_ADDR_11;
        endcase
    end

    // straps are caught after release, never under reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign slave_addr = q.addr;

    a_strap_address: assert property (@(posedge clk) disable iff (rst)
        ##1 ($past(q.straps) == 2'h0) |-> (q.addr == 7'h1E))
        else $error("strap 00 did not give its address");
endmodule

// *** rtl/i2c_register_slave_port.sv ***
// two-wire slave port giving a master byte access to a register file
`timescale 1ns/100ps
`include "i2c_slave_params.svh"
module i2c_register_slave_port (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic ADDR_STRAP_HIGH,
    input wire logic ADDR_STRAP_LOW,
    output logic [7:0] REG_INDEX,
    output logic [7:0] REG_WDATA,
    output logic REG_WRITE,
    output logic REG_READ,
    input wire logic [7:0] REG_RDATA,
    output logic BUS_BUSY,
    output logic ADDRESSED
);
    import i2c_slave_pkg::*;

    slave_regs_t q, d;
    logic [6:0] slave_addr;
    logic start_cond;
    logic stop_cond;
    logic byte_done;

    pin_if scl_l();
    pin_if sda_l();
    pin_if shi_l();
    pin_if slo_l();

    pin_sync u_scl (
        .clk(MCLK),
        .rst(RST),
        .pin(SCL_IN),
        .line(scl_l)
    );

    pin_sync u_sda (
        .clk(MCLK),
        .rst(RST),
        .pin(SDA_IN),
        .line(sda_l)
    );

    pin_sync u_shi (
        .clk(MCLK),
        .rst(RST),
        .pin(ADDR_STRAP_HIGH),
        .line(shi_l)
    );

    pin_sync u_slo (
        .clk(MCLK),
        .rst(RST),
        .pin(ADDR_STRAP_LOW),
        .line(slo_l)
    );

    addr_map u_map (
        .clk(MCLK),
        .rst(RST),
        .strap_hi(shi_l),
        .strap_lo(slo_l),
        .slave_addr(slave_addr)
    );

    assign start_cond = sda_l.fall & scl_l.level;
    assign stop_cond = sda_l.rise & scl_l.level;
    // eight bits in, ninth pulse is the slot
    assign byte_done = scl_l.fall & (q.cnt == `BYTE_BITS);

    always_comb begin
        d = q;
        d.wr = 1'b0;
        d.rd = 1'b0;
        if (q.rd || q.wr) begin
            d.ptr = q.ptr + `PTR_STEP;
        end
        if (start_cond) begin
            d.st = S_RECV;
            d.phase = PH_ADDR;
            d.cnt = '0;
            d.oe = 1'b0;
            d.busy = 1'b1;
            d.addressed = 1'b0;
        end else if (stop_cond) begin
            d.st = S_IDLE;
            d.oe = 1'b0;
            d.busy = 1'b0;
            d.addressed = 1'b0;
        end else begin
            case (q.st)
                S_IDLE: begin
                    d.oe = 1'b0;
                end
                S_RECV: begin
                    if (scl_l.rise) begin
                        d.shreg = {q.shreg[6:0], sda_l.level};
                        d.cnt = q.cnt + 4'h1;
                    end else if (byte_done) begin
                        d.cnt = '0;
                        case (q.phase)
                            PH_ADDR: begin
                                if (q.shreg[7:1] == slave_addr) begin
                                    d.rw = q.shreg[0];
                                    d.addressed = 1'b1;
                                    d.st = S_ACK;
                                    d.oe = 1'b1;
                                end else begin
                                    d.st = S_IGNORE;
                                end
                            end
                            PH_INDEX: begin
                                d.ptr = q.shreg;
                                d.st = S_ACK;
                                d.oe = 1'b1;
                            end
                            default: begin
                                d.wdata = q.shreg;
                                d.wr = 1'b1;
                                d.st = S_ACK;
                                d.oe = 1'b1;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    // hold low only until clock falls
                    if (scl_l.fall) begin
                        d.cnt = '0;
                        if (q.rw) begin
                            d.tx = REG_RDATA;
                            d.rd = 1'b1;
                            d.st = S_SEND;
                            d.oe = ~REG_RDATA[7];
                        end else begin
                            d.st = S_RECV;
                            d.oe = 1'b0;
                            if (q.phase == PH_ADDR) begin
                                d.phase = PH_INDEX;
                            end else begin
                                d.phase = PH_DATA;
                            end
                        end
                    end
                end
                S_SEND: begin
                    if (scl_l.fall) begin
                        if (q.cnt == `LAST_TX_BIT) begin
                            d.st = S_MACK;
                            d.oe = 1'b0;
                            d.cnt = '0;
                        end else begin
                            d.tx = {q.tx[6:0], 1'b0};
                            d.oe = ~q.tx[6];
                            d.cnt = q.cnt + 4'h1;
                        end
                    end
                end
                S_MACK: begin
                    if (scl_l.rise) begin
                        d.mack = ~sda_l.level;
                    end else if (scl_l.fall) begin
                        if (q.mack) begin
                            d.tx = REG_RDATA;
                            d.rd = 1'b1;
                            d.st = S_SEND;
                            d.oe = ~REG_RDATA[7];
                        end else begin
                            d.st = S_IGNORE;
                        end
                    end
                end
                S_IGNORE: begin
                    d.oe = 1'b0;
                end
                default: begin
                    d = SLAVE_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            q <= SLAVE_RESET;
        end else begin
            q <= d;
        end
    end

    // open drain: only ever drives low; clock pin is never driven
    assign SDA_OUT = q.sda_o;
    assign SDA_OE = q.oe;
    assign REG_INDEX = q.ptr;
    assign REG_WDATA = q.wdata;
    assign REG_WRITE = q.wr;
    assign REG_READ = q.rd;
    assign BUS_BUSY = q.busy;
    assign ADDRESSED = q.addressed;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    sequence quiet_edge;
        !start_cond && !stop_cond;
    endsequence

    sequence addr_byte_end;
        q.st == S_RECV && q.phase == PH_ADDR && byte_done ##0 quiet_edge;
    endsequence

    sequence data_byte_end;
        q.st == S_RECV && q.phase == PH_DATA && byte_done ##0 quiet_edge;
    endsequence

    a_addr_mismatch: assert property (
        addr_byte_end ##0 (q.shreg[7:1] != slave_addr)
        |=> q.st == S_IGNORE && !SDA_OE)
        else $error("mismatched address was not ignored");

    a_ninth_slot: assert property (
        $rose(q.st == S_ACK) |-> $past(q.cnt) == `BYTE_BITS)
        else $error("acknowledge slot not after eight bits");

    a_ack_held_low: assert property (
        (q.st == S_ACK && scl_l.level) ##0 quiet_edge |=> SDA_OE)
        else $error("acknowledge released during clock high");

    a_master_slot_free: assert property (
        q.st == S_MACK |-> !SDA_OE)
        else $error("data line driven in master slot");

    a_no_wait_state: assert property (
        (q.st == S_ACK && scl_l.fall) ##0 quiet_edge |=> q.st != S_ACK)
        else $error("acknowledge held past clock fall");

    a_start_restart: assert property (
        start_cond |=> q.st == S_RECV && q.cnt == 4'h0 &&
        q.phase == PH_ADDR && !SDA_OE)
        else $error("start did not restart address matching");

    a_stop_to_idle: assert property (
        stop_cond && !start_cond |=> q.st == S_IDLE && !SDA_OE)
        else $error("stop did not return to idle");

    a_busy_window: assert property (
        start_cond |=> BUS_BUSY)
        else $error("busy flag not raised by start");

    a_busy_hold: assert property (
        BUS_BUSY && !stop_cond |=> BUS_BUSY)
        else $error("busy flag dropped before stop");

    a_read_advance: assert property (
        REG_READ |=> REG_INDEX == $past(REG_INDEX) + `PTR_STEP)
        else $error("pointer did not advance after read");

    a_write_store: assert property (
        data_byte_end |=> REG_WRITE && REG_WDATA == $past(q.shreg) &&
        SDA_OE)
        else $error("data byte not stored and acknowledged");

    a_write_advance: assert property (
        REG_WRITE |=> REG_INDEX == $past(REG_INDEX) + `PTR_STEP)
        else $error("pointer did not advance after write");

    a_ignore_quiet: assert property (
        q.st == S_IGNORE |-> !SDA_OE [*2])
        else $error("data line driven while not addressed");
endmodule

// *** bench/i2c_master_model.sv ***
// behavioural two-wire bus master driving clock and data lines
`timescale 1ns/100ps
module i2c_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // extra low-phase cycles, a slow master the slave must simply follow
    int hold_low = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_cycle(input logic drv, output logic smp);
        repeat (2 + hold_low) @(negedge clk);
        sda_low = ~drv;
        repeat (2) @(negedge clk);
        scl = 1'b1;
        repeat (3) @(negedge clk);
        smp = sda;
        @(negedge clk);
        scl = 1'b0;
    endtask
    task automatic start_cond();
        // late release so a slave ack has ended before the clock rises
        repeat (5) @(negedge clk);
        sda_low = 1'b0;
        repeat (2) @(negedge clk);
        scl = 1'b1;
        repeat (4) @(negedge clk);
        sda_low = 1'b1;
        repeat (4) @(negedge clk);
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        repeat (2) @(negedge clk);
        sda_low = 1'b1;
        repeat (2) @(negedge clk);
        scl = 1'b1;
        repeat (4) @(negedge clk);
        sda_low = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(~ack, s);
    endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the two-wire register slave port
`timescale 1ns/100ps
module testbench;
    logic mclk, rst, strap_hi, strap_lo, scl, m_low;
    logic sda_out, sda_oe, reg_write, reg_read, bus_busy, addressed;
    logic [7:0] reg_index, reg_wdata, reg_rdata;
    logic [7:0] regs [256];
    int error_cnt = 0;
    int comparisons = 0;
    int rd_cnt = 0;
    // open drain with pull-up: the slave pulls only with its value low
    wire sda = ~((sda_oe & ~sda_out) | m_low);
    assign reg_rdata = regs[reg_index];
    i2c_register_slave_port u_i2c_register_slave_port (
        .MCLK(mclk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .ADDR_STRAP_HIGH(strap_hi), .ADDR_STRAP_LOW(strap_lo),
        .REG_INDEX(reg_index), .REG_WDATA(reg_wdata),
        .REG_WRITE(reg_write), .REG_READ(reg_read),
        .REG_RDATA(reg_rdata), .BUS_BUSY(bus_busy),
        .ADDRESSED(addressed)
    );
    i2c_master_model u_i2c_master_model (
        .clk(mclk), .sda(sda), .scl(scl), .sda_low(m_low)
    );
    always @(posedge mclk) begin
        if (reg_write === 1'b1) begin
            regs[reg_index] <= reg_wdata;
        end
        if (reg_read === 1'b1) begin
            rd_cnt <= rd_cnt + 1;
        end
    end
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // straps are static, so each setting gets its own reset
    task automatic do_reset(input logic [1:0] s);
        @(negedge mclk);
        rst = 1'b1;
        {strap_hi, strap_lo} = s;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (10) @(negedge mclk);
    endtask
    task automatic t_addr_select();
        logic [6:0] tbl [4];
        logic ack;
        tbl = '{7'h1E, 7'h1D, 7'h1C, 7'h1F};
        for (int s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            u_i2c_master_model.start_cond();
            u_i2c_master_model.send_byte({tbl[s] ^ 7'h01, 1'b0}, ack);
            chk({7'h00, ack}, 8'h00);
            chk({7'h00, addressed}, 8'h00);
            u_i2c_master_model.send_byte(8'h00, ack);
            chk({7'h00, ack}, 8'h00);
            u_i2c_master_model.start_cond();
            u_i2c_master_model.send_byte({tbl[s], 1'b0}, ack);
            chk({7'h00, ack}, 8'h01);
            chk({7'h00, addressed}, 8'h01);
            chk({7'h00, bus_busy}, 8'h01);
            u_i2c_master_model.send_byte(8'h10 + s[7:0], ack);
            u_i2c_master_model.send_byte(8'hA0 + s[7:0], ack);
            chk({7'h00, ack}, 8'h01);
            u_i2c_master_model.stop_cond();
            chk(regs[8'h10 + s[7:0]], 8'hA0 + s[7:0]);
            chk({6'h00, bus_busy, addressed}, 8'h00);
        end
    endtask
    task automatic t_burst_write();
        logic ack;
        logic [7:0] d [3];
        d = '{8'h11, 8'h22, 8'h33};
        do_reset(2'h0);
        u_i2c_master_model.hold_low = 6;
        u_i2c_master_model.start_cond();
        u_i2c_master_model.send_byte(8'h3C, ack);
        u_i2c_master_model.send_byte(8'hFE, ack);
        for (int i = 0; i < 3; i++) begin
            u_i2c_master_model.send_byte(d[i], ack);
            chk({7'h00, ack}, 8'h01);
        end
        u_i2c_master_model.stop_cond();
        u_i2c_master_model.hold_low = 0;
        chk(regs[8'hFE], 8'h11);
        chk(regs[8'hFF], 8'h22);
        chk(regs[8'h00], 8'h33);
        chk(reg_index, 8'h01);
    endtask
    task automatic t_burst_read();
        logic ack;
        logic [7:0] b;
        regs[8'h40] = 8'h5A;
        regs[8'h41] = 8'hA5;
        regs[8'h42] = 8'hC3;
        rd_cnt = 0;
        u_i2c_master_model.start_cond();
        u_i2c_master_model.send_byte(8'h3C, ack);
        u_i2c_master_model.send_byte(8'h40, ack);
        chk({7'h00, ack}, 8'h01);
        u_i2c_master_model.start_cond();
        u_i2c_master_model.send_byte(8'h3D, ack);
        chk({7'h00, ack}, 8'h01);
        u_i2c_master_model.recv_byte(1'b1, b);
        chk(b, 8'h5A);
        u_i2c_master_model.recv_byte(1'b1, b);
        chk(b, 8'hA5);
        u_i2c_master_model.recv_byte(1'b0, b);
        chk(b, 8'hC3);
        u_i2c_master_model.stop_cond();
        chk(rd_cnt[7:0], 8'h03);
        chk(reg_index, 8'h43);
        chk({6'h00, sda_oe, bus_busy}, 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        strap_hi = 1'b0;
        strap_lo = 1'b0;
        foreach (regs[i]) regs[i] = 8'h00;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        t_addr_select();
        t_burst_write();
        t_burst_read();
        tally_and_finish();
    end
    // run needs about 2830 cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
